// ### hw/cpgwt_consts.svh
// Offsets, field positions, reset values and timing counts of the cascaded pulse timer.
`ifndef CPGWT_CONSTS_SVH
`define CPGWT_CONSTS_SVH

`define CPGWT_ADDR_W 6
`define CPGWT_OFS_LOWER_CTRL 6'h00
`define CPGWT_OFS_UPPER_CTRL 6'h04
`define CPGWT_OFS_WIDTH_LOW 6'h08
`define CPGWT_OFS_WIDTH_HIGH 6'h0c
`define CPGWT_OFS_PERIOD_LOW 6'h10
`define CPGWT_OFS_PERIOD_HIGH 6'h14
`define CPGWT_OFS_COUNT 6'h18
`define CPGWT_OFS_IRQ_STATUS 6'h1c
`define CPGWT_OFS_IRQ_MASK 6'h20
`define CPGWT_OFS_PIN_STATE 6'h24

`define CPGWT_BIT_INIT 7
`define CPGWT_BIT_RUN 3
`define CPGWT_MODE_LSB 0
`define CPGWT_MODE_MSB 1
`define CPGWT_SRC_LSB 0
`define CPGWT_SRC_MSB 2
`define CPGWT_IRQ_MATCH 0

`define CPGWT_RST_CTRL 8'h00
`define CPGWT_RST_CMP 8'hff
`define CPGWT_RST_COUNT 16'h0000

`define CPGWT_PRESCALE_W 11
`define CPGWT_DIV_11 11'h7ff
`define CPGWT_DIV_7 11'h07f
`define CPGWT_DIV_5 11'h01f
`define CPGWT_DIV_3 11'h007
`define CPGWT_DIV_1 11'h001

`endif

// ### hw/cpgwt_pkg.sv
// Types shared by the cascaded pulse timer files.
package cpgwt_pkg;

  typedef enum logic [1:0] {
    CPGWT_MODE_IDLE = 2'b00,
    CPGWT_MODE_PULSE = 2'b01,
    CPGWT_MODE_WARMUP = 2'b10,
    CPGWT_MODE_RSVD = 2'b11
  } cpgwt_mode_t;

  typedef enum logic [2:0] {
    CPGWT_SRC_DIV11 = 3'h0,
    CPGWT_SRC_DIV7 = 3'h1,
    CPGWT_SRC_DIV5 = 3'h2,
    CPGWT_SRC_DIV3 = 3'h3,
    CPGWT_SRC_DIV1 = 3'h4,
    CPGWT_SRC_CLK = 3'h5,
    CPGWT_SRC_PIN = 3'h6,
    CPGWT_SRC_OFF = 3'h7
  } cpgwt_src_t;

endpackage

// ### hw/cpgwt_pin_edge.sv
// Synchroniser and falling-edge detector for the external count pin.
`timescale 1ns/1ps
`default_nettype none
module cpgwt_pin_edge (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic fall_o
);

  logic [2:0] sync_reg;
  logic level_reg;

  // Three stages; the first feeds only the second.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_reg <= 3'h7;
    end else begin
      sync_reg <= {sync_reg[1:0], pin_i};
    end
  end

  // The level changes only once stages two and three agree.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level_reg <= 1'b1;
    end else if (sync_reg[1] == sync_reg[2]) begin
      level_reg <= sync_reg[2];
    end
  end

  assign fall_o = level_reg & (sync_reg[1] == sync_reg[2]) & ~sync_reg[2];

endmodule
`default_nettype wire

// ### hw/cpgwt_top.sv
// Cascaded 16-bit pulse generator and warm-up timer with its Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
`include "cpgwt_consts.svh"
// Behaviour
// - Counter steps on the chosen prescaled tick, every clock or on external pin falling edge; low byte first timer.
// - Pulse mode: count equal to width register inverts output flop, counting continues.
// - Pulse mode: count equal to period inverts flop, clears count, raises interrupt.
// - Output flop starts from the initial-level bit; reset clears it to zero.
// - Pulse output pin always drives the inverse of the output flop.
// - Compare registers are not buffered; writes reach the comparison at once.
// - Stopped counter holds the pin; level changes by a later init-bit write.
// - Warm-up mode compares only the upper period byte, ignoring the lower byte.
// - Warm-up counting starts on run bit; period match raises interrupt, clears count.
module cpgwt_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`CPGWT_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic count_pin_i,
  output logic pulse_out_pin_o,
  output logic upper_timer_irq_o
);

  logic [7:0] lower_timer_ctrl_reg;
  logic [7:0] upper_timer_ctrl_reg;
  logic [7:0] width_cmp_low_reg;
  logic [7:0] width_cmp_high_reg;
  logic [7:0] period_cmp_low_reg;
  logic [7:0] period_cmp_high_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic output_flop_reg;
  logic irq_status_reg;
  logic irq_mask_reg;
  logic [`CPGWT_PRESCALE_W-1:0] prescale_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic pin_fall;
  logic tick;
  logic run;
  logic wr_go;
  logic wr_upper;
  logic width_hit;
  logic period_hit;
  logic match_event;
  cpgwt_pkg::cpgwt_mode_t mode;
  cpgwt_pkg::cpgwt_src_t src;

  cpgwt_pin_edge u_pin_edge (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(count_pin_i),
    .fall_o(pin_fall)
  );

  assign mode = cpgwt_pkg::cpgwt_mode_t'(upper_timer_ctrl_reg[`CPGWT_MODE_MSB:`CPGWT_MODE_LSB]);
  assign src = cpgwt_pkg::cpgwt_src_t'(lower_timer_ctrl_reg[`CPGWT_SRC_MSB:`CPGWT_SRC_LSB]);
  assign run = upper_timer_ctrl_reg[`CPGWT_BIT_RUN];

  // Bus slave: one wait state, then the request is taken.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_go = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign wr_upper = wr_go & (avs_address_i == `CPGWT_OFS_UPPER_CTRL);
  assign avs_readdata_o = readdata_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_reg) begin
      unique case (avs_address_i)
        `CPGWT_OFS_LOWER_CTRL: readdata_reg <= {24'h00_0000, lower_timer_ctrl_reg};
        `CPGWT_OFS_UPPER_CTRL: readdata_reg <= {24'h00_0000, upper_timer_ctrl_reg};
        `CPGWT_OFS_WIDTH_LOW: readdata_reg <= {24'h00_0000, width_cmp_low_reg};
        `CPGWT_OFS_WIDTH_HIGH: readdata_reg <= {24'h00_0000, width_cmp_high_reg};
        `CPGWT_OFS_PERIOD_LOW: readdata_reg <= {24'h00_0000, period_cmp_low_reg};
        `CPGWT_OFS_PERIOD_HIGH: readdata_reg <= {24'h00_0000, period_cmp_high_reg};
        `CPGWT_OFS_COUNT: readdata_reg <= {16'h0000, count_reg};
        `CPGWT_OFS_IRQ_STATUS: readdata_reg <= {31'h0000_0000, irq_status_reg};
        `CPGWT_OFS_IRQ_MASK: readdata_reg <= {31'h0000_0000, irq_mask_reg};
        `CPGWT_OFS_PIN_STATE: readdata_reg <= {31'h0000_0000, pulse_out_pin_o};
        default: readdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control and compare registers.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lower_timer_ctrl_reg <= `CPGWT_RST_CTRL;
      upper_timer_ctrl_reg <= `CPGWT_RST_CTRL;
      width_cmp_low_reg <= `CPGWT_RST_CMP;
      width_cmp_high_reg <= `CPGWT_RST_CMP;
      period_cmp_low_reg <= `CPGWT_RST_CMP;
      period_cmp_high_reg <= `CPGWT_RST_CMP;
      irq_mask_reg <= 1'b0;
    end else if (wr_go) begin
      // Compare writes reach the comparators on the next edge.
      // no shadow buffer
      unique case (avs_address_i)
        `CPGWT_OFS_LOWER_CTRL: lower_timer_ctrl_reg <= avs_writedata_i[7:0];
        `CPGWT_OFS_UPPER_CTRL: upper_timer_ctrl_reg <= avs_writedata_i[7:0];
        `CPGWT_OFS_WIDTH_LOW: width_cmp_low_reg <= avs_writedata_i[7:0];
        `CPGWT_OFS_WIDTH_HIGH: width_cmp_high_reg <= avs_writedata_i[7:0];
        `CPGWT_OFS_PERIOD_LOW: period_cmp_low_reg <= avs_writedata_i[7:0];
        `CPGWT_OFS_PERIOD_HIGH: period_cmp_high_reg <= avs_writedata_i[7:0];
        `CPGWT_OFS_IRQ_MASK: irq_mask_reg <= avs_writedata_i[`CPGWT_IRQ_MATCH];
        default: irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end

  // Free-running prescaler for the internal tick sources.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + `CPGWT_PRESCALE_W'(1);
    end
  end

  always_comb begin
    unique case (src)
      cpgwt_pkg::CPGWT_SRC_DIV11: tick = (prescale_reg & `CPGWT_DIV_11) == `CPGWT_DIV_11;
      cpgwt_pkg::CPGWT_SRC_DIV7: tick = (prescale_reg & `CPGWT_DIV_7) == `CPGWT_DIV_7;
      cpgwt_pkg::CPGWT_SRC_DIV5: tick = (prescale_reg & `CPGWT_DIV_5) == `CPGWT_DIV_5;
      cpgwt_pkg::CPGWT_SRC_DIV3: tick = (prescale_reg & `CPGWT_DIV_3) == `CPGWT_DIV_3;
      cpgwt_pkg::CPGWT_SRC_DIV1: tick = (prescale_reg & `CPGWT_DIV_1) == `CPGWT_DIV_1;
      cpgwt_pkg::CPGWT_SRC_CLK: tick = 1'b1;
      cpgwt_pkg::CPGWT_SRC_PIN: tick = pin_fall;
      cpgwt_pkg::CPGWT_SRC_OFF: tick = 1'b0;
    endcase
  end

  // warm-up uses only the upper byte
  always_comb begin
    width_hit = 1'b0;
    period_hit = 1'b0;
    if (mode == cpgwt_pkg::CPGWT_MODE_PULSE) begin
      width_hit = count_reg == {width_cmp_high_reg, width_cmp_low_reg};
      period_hit = count_reg == {period_cmp_high_reg, period_cmp_low_reg};
    end else if (mode == cpgwt_pkg::CPGWT_MODE_WARMUP) begin
      period_hit = count_reg[15:8] == period_cmp_high_reg;
    end
  end

  assign match_event = run & tick & period_hit;

  // count while running, clear on period match
  always_comb begin
    count_next = count_reg;
    if (run & tick) begin
      if (period_hit) begin
        count_next = `CPGWT_RST_COUNT;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_reg <= `CPGWT_RST_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // flop reset to zero, loaded from init bit
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      output_flop_reg <= 1'b0;
    end else if (run & tick & mode == cpgwt_pkg::CPGWT_MODE_PULSE & (width_hit ^ period_hit)) begin
      output_flop_reg <= ~output_flop_reg;
    end else if (wr_upper & ~run & ~avs_writedata_i[`CPGWT_BIT_RUN]) begin
      // reload only on a write made while stopped
      output_flop_reg <= avs_writedata_i[`CPGWT_BIT_INIT];
    end else if (wr_upper & ~run) begin
      output_flop_reg <= avs_writedata_i[`CPGWT_BIT_INIT];
    end
  end

  assign pulse_out_pin_o = ~output_flop_reg;

  // period match raises the interrupt; set wins over clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_status_reg <= 1'b0;
    end else if (match_event) begin
      irq_status_reg <= 1'b1;
    end else if (wr_go & avs_address_i == `CPGWT_OFS_IRQ_STATUS) begin
      irq_status_reg <= irq_status_reg & ~avs_writedata_i[`CPGWT_IRQ_MATCH];
    end
  end

  assign upper_timer_irq_o = irq_status_reg & irq_mask_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_count_step: assert property (run && tick && !period_hit |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("Counter did not step on a tick.");

  a_width_toggle: assert property (
    run && tick && mode == cpgwt_pkg::CPGWT_MODE_PULSE && width_hit && !period_hit
    |=> output_flop_reg != $past(output_flop_reg) && count_reg != 16'h0000)
    else $error("Width match did not invert the flop.");

  a_period_clear: assert property (
    run && tick && mode == cpgwt_pkg::CPGWT_MODE_PULSE && period_hit && !width_hit
    |=> count_reg == 16'h0000 && irq_status_reg && output_flop_reg != $past(output_flop_reg))
    else $error("Period match did not clear, toggle and flag.");

  a_init_load: assert property (wr_upper && !run |=> output_flop_reg == $past(avs_writedata_i[7]))
    else $error("Stopped write did not load the initial level.");

  a_pin_inverse: assert property (pulse_out_pin_o == !output_flop_reg)
    else $error("Pulse pin is not the inverted flop.");

  a_cmp_immediate: assert property (wr_go && avs_address_i == `CPGWT_OFS_PERIOD_HIGH
    |=> period_cmp_high_reg == $past(avs_writedata_i[7:0]))
    else $error("Period write did not take effect at once.");

  a_stop_holds: assert property (!run && !wr_upper |=> $stable(output_flop_reg) && $stable(count_reg))
    else $error("Stopped timer changed its output or count.");

  a_warm_match: assert property (
    run && tick && mode == cpgwt_pkg::CPGWT_MODE_WARMUP && count_reg[15:8] == period_cmp_high_reg
    |=> count_reg == 16'h0000 && irq_status_reg)
    else $error("Warm-up upper-byte match missed.");

  a_warm_run: assert property (mode == cpgwt_pkg::CPGWT_MODE_WARMUP && !run |=> $stable(count_reg))
    else $error("Warm-up counter moved while stopped.");

  a_bus_answer: assert property ((avs_read_i || avs_write_i) && !ack_reg |=> !avs_waitrequest_o)
    else $error("Bus answer took more than one wait state.");

  a_count_hold: assert property (run && !tick |=> $stable(count_reg))
    else $error("Counter moved without a tick.");

  a_pin_source: assert property (run && src == cpgwt_pkg::CPGWT_SRC_PIN && !pin_fall
    |=> $stable(count_reg))
    else $error("Counter moved without a pin edge.");

  a_stop_no_reload: assert property (
    wr_upper && run
    && !(tick && mode == cpgwt_pkg::CPGWT_MODE_PULSE && (width_hit ^ period_hit))
    |=> $stable(output_flop_reg))
    else $error("Write to a running timer changed the output flop.");

  a_irq_set_wins: assert property (match_event |=> irq_status_reg)
    else $error("Period match did not set the status bit.");

  a_irq_clear: assert property (wr_go && avs_address_i == `CPGWT_OFS_IRQ_STATUS
    && avs_writedata_i[`CPGWT_IRQ_MATCH] && !match_event |=> !irq_status_reg)
    else $error("Writing one did not clear the status bit.");

  a_width_immediate: assert property (wr_go && avs_address_i == `CPGWT_OFS_WIDTH_LOW
    |=> width_cmp_low_reg == $past(avs_writedata_i[7:0]))
    else $error("Width write did not take effect at once.");

  a_warm_low_ignored: assert property (
    run && tick && mode == cpgwt_pkg::CPGWT_MODE_WARMUP && count_reg != 16'hffff
    && count_reg[15:8] != period_cmp_high_reg |=> count_reg != 16'h0000)
    else $error("Warm-up cleared without an upper-byte match.");

  a_width_no_irq: assert property (
    run && tick && mode == cpgwt_pkg::CPGWT_MODE_PULSE && width_hit && !period_hit
    && !irq_status_reg |=> !irq_status_reg)
    else $error("Width match raised the interrupt.");

  c_pulse_period: cover property (match_event && mode == cpgwt_pkg::CPGWT_MODE_PULSE);
  c_warm_match: cover property (match_event && mode == cpgwt_pkg::CPGWT_MODE_WARMUP);
  c_pin_count: cover property (run && src == cpgwt_pkg::CPGWT_SRC_PIN && pin_fall);
  c_irq_out: cover property (upper_timer_irq_o);
  c_stop_write: cover property (wr_upper && run && !avs_writedata_i[`CPGWT_BIT_RUN]);

endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking testbench for the cascaded pulse timer.
`timescale 1ns/1ps
`default_nettype none
`include "cpgwt_consts.svh"
module testbench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wait_o;
  logic pin_o;
  logic irq_o;
  logic cnt_pin = 1'b1;
  logic held;
  logic [31:0] q;
  int errors = 0;
  int total_checks = 0;
  int lo;
  int hi;
  int n;

  always #5 clk_i = ~clk_i;

  cpgwt_top u_dut (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdat),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o),
    .count_pin_i(cnt_pin),
    .pulse_out_pin_o(pin_o),
    .upper_timer_irq_o(irq_o)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low, then takes read data.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    adr <= a;
    wdat <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk_i);
      k++;
    end while (wait_o !== 1'b0 && k < 20);
    if (k >= 20) check("bus answer", 32'h1, 32'h0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask

  // Measures one low and the following high phase of the pulse pin in clocks.
  task automatic pin_lens;
    n = 0;
    while (pin_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    while (pin_o !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    lo = 0;
    while (pin_o === 1'b0 && lo < 100) begin
      @(posedge clk_i);
      lo++;
    end
    hi = 0;
    while (pin_o === 1'b1 && hi < 100) begin
      @(posedge clk_i);
      hi++;
    end
  endtask

  task automatic test_reset_map;
    check("pin after reset", {31'h0, pin_o}, 32'h1);
    check("irq after reset", {31'h0, irq_o}, 32'h0);
    bus(1'b0, `CPGWT_OFS_WIDTH_LOW, 8'h00);
    check("width reset", q, 32'h000000ff);
    bus(1'b0, 6'h3c, 8'h00);
    check("unmapped read", q, 32'h0);
    be <= 4'h0;
    bus(1'b1, `CPGWT_OFS_WIDTH_LOW, 8'h12);
    be <= 4'hf;
    bus(1'b0, `CPGWT_OFS_WIDTH_LOW, 8'h00);
    check("masked write", q, 32'h000000ff);
  endtask

  task automatic test_pulse_irq;
    bus(1'b1, `CPGWT_OFS_LOWER_CTRL, 8'h05);
    // low byte first, width below period.
    bus(1'b1, `CPGWT_OFS_WIDTH_LOW, 8'h03);
    bus(1'b1, `CPGWT_OFS_WIDTH_HIGH, 8'h00);
    bus(1'b1, `CPGWT_OFS_PERIOD_LOW, 8'h06);
    bus(1'b1, `CPGWT_OFS_PERIOD_HIGH, 8'h00);
    // port latch lies outside this block.
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h01);
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h09);
    pin_lens();
    check("pulse low len", lo, 32'd3);
    check("pulse high len", hi, 32'd4);
    bus(1'b0, `CPGWT_OFS_IRQ_STATUS, 8'h00);
    check("period status", {31'h0, q[0]}, 32'h1);
    check("masked irq", {31'h0, irq_o}, 32'h0);
    bus(1'b1, `CPGWT_OFS_IRQ_MASK, 8'h01);
    @(posedge clk_i);
    check("unmasked irq", {31'h0, irq_o}, 32'h1);
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h01);
    @(posedge clk_i);
    held = pin_o;
    repeat (12) @(posedge clk_i);
    check("pin held", {31'h0, pin_o}, {31'h0, held});
    bus(1'b1, `CPGWT_OFS_IRQ_STATUS, 8'h01);
    @(posedge clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h81);
    @(posedge clk_i);
    check("init one", {31'h0, pin_o}, 32'h0);
    bus(1'b0, `CPGWT_OFS_PIN_STATE, 8'h00);
    check("pin state reg", q, 32'h0);
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h01);
    @(posedge clk_i);
    check("init zero", {31'h0, pin_o}, 32'h1);
  endtask

  task automatic test_warmup;
    do_reset();
    bus(1'b1, `CPGWT_OFS_LOWER_CTRL, 8'h05);
    // low byte first, smallest usable upper byte.
    bus(1'b1, `CPGWT_OFS_PERIOD_LOW, 8'h55);
    bus(1'b1, `CPGWT_OFS_PERIOD_HIGH, 8'h01);
    bus(1'b1, `CPGWT_OFS_IRQ_MASK, 8'h01);
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h0a);
    n = 0;
    while (irq_o !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    check("warmup span", {31'h0, (n >= 256 && n <= 262)}, 32'h1);
    bus(1'b0, `CPGWT_OFS_COUNT, 8'h00);
    check("warmup cleared", {31'h0, (q[15:0] < 16'h0010)}, 32'h1);
    // stop once the interrupt is seen.
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h02);
  endtask

  task automatic test_ext_pin;
    do_reset();
    bus(1'b1, `CPGWT_OFS_LOWER_CTRL, 8'h06);
    bus(1'b1, `CPGWT_OFS_UPPER_CTRL, 8'h09);
    // each phase held for three clocks.
    for (int i = 0; i < 5; i++) begin
      cnt_pin <= 1'b0;
      repeat (3) @(posedge clk_i);
      cnt_pin <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    bus(1'b0, `CPGWT_OFS_COUNT, 8'h00);
    check("pin edge count", {16'h0, q[15:0]}, 32'h5);
    // tick every second clock, then none.
    bus(1'b1, `CPGWT_OFS_LOWER_CTRL, 8'h04);
    bus(1'b0, `CPGWT_OFS_COUNT, 8'h00);
    lo = q[15:0];
    repeat (19) @(posedge clk_i);
    bus(1'b0, `CPGWT_OFS_COUNT, 8'h00);
    check("half rate count", {16'h0, q[15:0] - lo[15:0]}, 32'd11);
    bus(1'b1, `CPGWT_OFS_LOWER_CTRL, 8'h07);
    bus(1'b0, `CPGWT_OFS_COUNT, 8'h00);
    lo = q[15:0];
    repeat (19) @(posedge clk_i);
    bus(1'b0, `CPGWT_OFS_COUNT, 8'h00);
    check("source off count", {16'h0, q[15:0] - lo[15:0]}, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    test_reset_map();
    test_pulse_irq();
    test_warmup();
    test_ext_pin();
    final_report();
  end

  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
